//--- core/timer16_pkg.sv
// Functional notes
// - Counter is sixteen bits wide and counts up or down.
// - Low-byte read copies counter high byte into shared latch; high read returns latch.
// - Low-byte write loads all sixteen bits, upper byte taken from the latch.
// - Clock select zero gives no tick, so counting stops.
// - Counter stays readable and writable with or without ticks.
// - Software counter write wins; a coincident count or clear is dropped.
// - Each tick clears, increments or decrements by one, as the mode says.
// - Four-bit waveform mode is split over control registers A and B.
// - Tick comes from prescaler taps or edges on the external count pin.
// - Top and bottom indications show when counter reaches top or zero.
// - Overflow flag sets at the point the mode defines.
// - Top comes from compare A, capture value or a fixed constant.
// - Compare A as top in PWM modes is double buffered.
// - Both compare values are matched continuously; a match sets its flag on a tick.
// - Capture copies the counter on a filtered pin or comparator edge, except in modes that use the capture value as top.
// - Four flag sources, each gated by its own mask bit.
// - Eight-bit control registers take single accesses without latch ordering.
// - Noise canceler passes a change only after four equal samples.
// - Capture flag sets in the same cycle the capture value loads.
package timer16_pkg;
  // ----------------------------------------------------------------
  // Register selectors
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_CNT_L = 4'h0;
  localparam logic [3:0] SEL_CNT_H = 4'h1;
  localparam logic [3:0] SEL_CMPA_L = 4'h2;
  localparam logic [3:0] SEL_CMPA_H = 4'h3;
  localparam logic [3:0] SEL_CMPB_L = 4'h4;
  localparam logic [3:0] SEL_CMPB_H = 4'h5;
  localparam logic [3:0] SEL_CAP_L = 4'h6;
  localparam logic [3:0] SEL_CAP_H = 4'h7;
  localparam logic [3:0] SEL_CTRL_A = 4'h8;
  localparam logic [3:0] SEL_CTRL_B = 4'h9;
  localparam logic [3:0] SEL_FLAGS = 4'ha;
  localparam logic [3:0] SEL_MASK = 4'hb;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRLB_NOISE_BIT = 7;
  localparam int CTRLB_EDGE_BIT = 6;
  localparam logic [7:0] CTRLB_RW_MASK = 8'hdf;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAP = 5;
  localparam logic [7:0] FLAG_RW_MASK = 8'h27;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_TAP_FIRST = 3'h1;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int NUM_TAPS = 5;
  // ----------------------------------------------------------------
  // Counter limits and modes
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_CTC_CMPA = 4'h4;
  localparam logic [3:0] WM_CTC_CAP = 4'hc;
  localparam logic [3:0] WM_RESERVED = 4'hd;
  localparam int FILTER_DEPTH = 4;
endpackage

//--- core/tick_select.sv
`timescale 1ns/1ps
module tick_select (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] clockSel,
  input wire logic [timer16_pkg::NUM_TAPS-1:0] prescTaps,
  input wire logic extCountPin,
  output logic tick
);
  logic extPrev_ff;
  logic nxt_extPrev;
  logic extRise;
  logic extFall;
  logic [2:0] tapIdx;

  always_comb begin
    nxt_extPrev = extCountPin;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extPrev_ff <= 1'b0;
    end else begin
      extPrev_ff <= nxt_extPrev;
    end
  end

  assign extRise = extCountPin & ~extPrev_ff;
  assign extFall = ~extCountPin & extPrev_ff;
  assign tapIdx = clockSel - timer16_pkg::CS_TAP_FIRST;

  // ----------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------
  always_comb begin
    if (clockSel == timer16_pkg::CS_STOP) begin
      tick = 1'b0;
    end else if (clockSel == timer16_pkg::CS_EXT_FALL) begin
      tick = extFall;
    end else if (clockSel == timer16_pkg::CS_EXT_RISE) begin
      tick = extRise;
    end else begin
      tick = prescTaps[tapIdx];
    end
  end
endmodule

//--- core/capture_filter.sv
`timescale 1ns/1ps
module capture_filter (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rawIn,
  input wire logic noiseEn,
  input wire logic risingEdge,
  output logic capEvent
);
  localparam int D = timer16_pkg::FILTER_DEPTH;
  logic [D-1:0] samples_ff;
  logic filt_ff;
  logic prev_ff;
  logic [D-1:0] nxt_samples;
  logic nxt_filt;
  logic nxt_prev;
  logic allSame;

  always_comb begin
    nxt_samples = {samples_ff[D-2:0], rawIn};
    allSame = (&samples_ff) | (~|samples_ff);
    nxt_filt = noiseEn ? (allSame ? samples_ff[0] : filt_ff) : rawIn;
    nxt_prev = filt_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      samples_ff <= '0;
      filt_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      samples_ff <= nxt_samples;
      filt_ff <= nxt_filt;
      prev_ff <= nxt_prev;
    end
  end

  assign capEvent = risingEdge ? (filt_ff & ~prev_ff) : (~filt_ff & prev_ff);

  property p_filterHold;
    @(posedge clk) disable iff (!arst_n)
      noiseEn && $past(noiseEn) && (filt_ff != $past(filt_ff))
        |-> $past(allSame);
  endproperty
  a_filterHold: assert property (p_filterHold) else $error("filter changed early");
endmodule

//--- core/timer16_counter_core.sv
`timescale 1ns/1ps
module timer16_counter_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] cpuSel,
  input wire logic cpuWrEn,
  input wire logic cpuRdEn,
  input wire logic [7:0] cpuWrData,
  output logic [7:0] cpuRdData,
  input wire logic [timer16_pkg::NUM_TAPS-1:0] prescTaps,
  input wire logic extCountPin,
  input wire logic capturePin,
  input wire logic comparatorOut,
  input wire logic acCaptureSel,
  output logic [15:0] counterValue,
  output logic topHit,
  output logic bottomHit,
  output logic matchA,
  output logic matchB,
  output logic [3:0] intReq
);
  typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_t;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic logic isDual(input logic [3:0] m);
    return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
  endfunction

  function automatic logic isPwm(input logic [3:0] m);
    return !(m inside {timer16_pkg::WM_NORMAL, timer16_pkg::WM_CTC_CMPA,
                       timer16_pkg::WM_CTC_CAP, timer16_pkg::WM_RESERVED});
  endfunction

  function automatic logic capIsTop(input logic [3:0] m);
    return (m inside {4'h8, 4'ha, timer16_pkg::WM_CTC_CAP, 4'he});
  endfunction

  function automatic logic [15:0] modeTop(input logic [3:0] m, input logic [15:0] a,
                                          input logic [15:0] c);
    logic [15:0] t;
    t = timer16_pkg::CNT_MAX;
    if (m inside {4'h1, 4'h5}) begin
      t = timer16_pkg::TOP_8BIT;
    end else if (m inside {4'h2, 4'h6}) begin
      t = timer16_pkg::TOP_9BIT;
    end else if (m inside {4'h3, 4'h7}) begin
      t = timer16_pkg::TOP_10BIT;
    end else if (m inside {timer16_pkg::WM_CTC_CMPA, 4'h9, 4'hb, 4'hf}) begin
      t = a;
    end else if (capIsTop(m)) begin
      t = c;
    end
    return t;
  endfunction

  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] cmpA_ff, nxt_cmpA, cmpABuf_ff, nxt_cmpABuf;
  logic [15:0] cmpB_ff, nxt_cmpB, cmpBBuf_ff, nxt_cmpBBuf;
  logic [15:0] cap_ff, nxt_cap;
  logic [7:0] temp_ff, nxt_temp;
  logic [7:0] ctrlA_ff, nxt_ctrlA, ctrlB_ff, nxt_ctrlB;
  logic [7:0] flags_ff, nxt_flags, mask_ff, nxt_mask;
  logic [7:0] rdData_ff, nxt_rdData;
  dir_t dir_ff, nxt_dir;
  logic [3:0] mode;
  logic [15:0] top;
  logic tick, capEvent, capSrc, cntWr, atTop, atBottom, bufLoad;
  logic [7:0] flagSet, flagClr;

  assign mode = {ctrlB_ff[4:3], ctrlA_ff[1:0]};
  assign top = modeTop(mode, cmpA_ff, cap_ff);
  assign atTop = (cnt_ff == top);
  assign atBottom = (cnt_ff == timer16_pkg::CNT_BOTTOM);
  assign cntWr = cpuWrEn && (cpuSel == timer16_pkg::SEL_CNT_L);
  assign capSrc = acCaptureSel ? comparatorOut : capturePin;

  tick_select u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .clockSel(ctrlB_ff[2:0]),
    .prescTaps(prescTaps),
    .extCountPin(extCountPin),
    .tick(tick)
  );

  capture_filter u_capf (
    .clk(clk),
    .arst_n(arst_n),
    .rawIn(capSrc),
    .noiseEn(ctrlB_ff[timer16_pkg::CTRLB_NOISE_BIT]),
    .risingEdge(ctrlB_ff[timer16_pkg::CTRLB_EDGE_BIT]),
    .capEvent(capEvent)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    nxt_cmpA = cmpA_ff;
    nxt_cmpB = cmpB_ff;
    nxt_cmpABuf = cmpABuf_ff;
    nxt_cmpBBuf = cmpBBuf_ff;
    nxt_cap = cap_ff;
    nxt_temp = temp_ff;
    nxt_ctrlA = ctrlA_ff;
    nxt_ctrlB = ctrlB_ff;
    nxt_mask = mask_ff;
    nxt_rdData = rdData_ff;
    flagSet = '0;
    flagClr = '0;
    bufLoad = 1'b0;
    if (tick) begin
      if (isDual(mode)) begin
        if (dir_ff == DIR_UP) begin
          if (atTop) begin
            nxt_dir = DIR_DOWN;
            nxt_cnt = 16'(cnt_ff - timer16_pkg::CNT_ONE);
          end else begin
            nxt_cnt = 16'(cnt_ff + timer16_pkg::CNT_ONE);
          end
        end else begin
          if (atBottom) begin
            nxt_dir = DIR_UP;
            nxt_cnt = 16'(cnt_ff + timer16_pkg::CNT_ONE);
            flagSet[timer16_pkg::FLAG_OVF] = 1'b1;
          end else begin
            nxt_cnt = 16'(cnt_ff - timer16_pkg::CNT_ONE);
          end
        end
        bufLoad = (mode inside {4'h8, 4'h9}) ? atBottom : atTop;
      end else begin
        nxt_dir = DIR_UP;
        if (atTop) begin
          nxt_cnt = timer16_pkg::CNT_BOTTOM;
        end else begin
          nxt_cnt = 16'(cnt_ff + timer16_pkg::CNT_ONE);
        end
        if (mode inside {timer16_pkg::WM_CTC_CMPA, timer16_pkg::WM_CTC_CAP}) begin
          flagSet[timer16_pkg::FLAG_OVF] = (cnt_ff == timer16_pkg::CNT_MAX);
        end else begin
          flagSet[timer16_pkg::FLAG_OVF] = atTop;
        end
        bufLoad = atTop;
      end
      flagSet[timer16_pkg::FLAG_CMPA] = matchA;
      flagSet[timer16_pkg::FLAG_CMPB] = matchB;
    end
    if (isPwm(mode)) begin
      if (bufLoad) begin
        nxt_cmpA = cmpABuf_ff;
        nxt_cmpB = cmpBBuf_ff;
      end
    end else begin
      nxt_cmpA = cmpABuf_ff;
      nxt_cmpB = cmpBBuf_ff;
    end
    if (capEvent && !capIsTop(mode)) begin
      nxt_cap = cnt_ff;
      flagSet[timer16_pkg::FLAG_CAP] = 1'b1;
    end
    if (cpuRdEn) begin
      nxt_rdData = timer16_pkg::RST_BYTE;
      unique case (cpuSel)
        timer16_pkg::SEL_CNT_L: begin
          nxt_rdData = cnt_ff[7:0];
          nxt_temp = cnt_ff[15:8];
        end
        timer16_pkg::SEL_CAP_L: begin
          nxt_rdData = cap_ff[7:0];
          nxt_temp = cap_ff[15:8];
        end
        timer16_pkg::SEL_CNT_H, timer16_pkg::SEL_CAP_H: nxt_rdData = temp_ff;
        timer16_pkg::SEL_CMPA_L: nxt_rdData = cmpABuf_ff[7:0];
        timer16_pkg::SEL_CMPA_H: nxt_rdData = cmpABuf_ff[15:8];
        timer16_pkg::SEL_CMPB_L: nxt_rdData = cmpBBuf_ff[7:0];
        timer16_pkg::SEL_CMPB_H: nxt_rdData = cmpBBuf_ff[15:8];
        timer16_pkg::SEL_CTRL_A: nxt_rdData = ctrlA_ff;
        timer16_pkg::SEL_CTRL_B: nxt_rdData = ctrlB_ff;
        timer16_pkg::SEL_FLAGS: nxt_rdData = flags_ff;
        timer16_pkg::SEL_MASK: nxt_rdData = mask_ff;
        default: nxt_rdData = timer16_pkg::RST_BYTE;
      endcase
    end
    if (cpuWrEn) begin
      unique case (cpuSel)
        timer16_pkg::SEL_CNT_H, timer16_pkg::SEL_CMPA_H, timer16_pkg::SEL_CMPB_H,
        timer16_pkg::SEL_CAP_H: nxt_temp = cpuWrData;
        timer16_pkg::SEL_CNT_L: nxt_cnt = {temp_ff, cpuWrData};
        timer16_pkg::SEL_CMPA_L: nxt_cmpABuf = {temp_ff, cpuWrData};
        timer16_pkg::SEL_CMPB_L: nxt_cmpBBuf = {temp_ff, cpuWrData};
        timer16_pkg::SEL_CAP_L: begin
          if (capIsTop(mode)) begin
            nxt_cap = {temp_ff, cpuWrData};
          end
        end
        timer16_pkg::SEL_CTRL_A: nxt_ctrlA = cpuWrData;
        timer16_pkg::SEL_CTRL_B: nxt_ctrlB = cpuWrData & timer16_pkg::CTRLB_RW_MASK;
        timer16_pkg::SEL_FLAGS: flagClr = cpuWrData & timer16_pkg::FLAG_RW_MASK;
        timer16_pkg::SEL_MASK: nxt_mask = cpuWrData & timer16_pkg::FLAG_RW_MASK;
        default: nxt_temp = temp_ff;
      endcase
    end
    nxt_flags = (flags_ff & ~flagClr) | flagSet;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= timer16_pkg::RST_WORD;
      dir_ff <= DIR_UP;
      cmpA_ff <= timer16_pkg::RST_WORD;
      cmpB_ff <= timer16_pkg::RST_WORD;
      cmpABuf_ff <= timer16_pkg::RST_WORD;
      cmpBBuf_ff <= timer16_pkg::RST_WORD;
      cap_ff <= timer16_pkg::RST_WORD;
      temp_ff <= timer16_pkg::RST_BYTE;
      ctrlA_ff <= timer16_pkg::RST_BYTE;
      ctrlB_ff <= timer16_pkg::RST_BYTE;
      flags_ff <= timer16_pkg::RST_BYTE;
      mask_ff <= timer16_pkg::RST_BYTE;
      rdData_ff <= timer16_pkg::RST_BYTE;
    end else begin
      cnt_ff <= nxt_cnt;
      dir_ff <= nxt_dir;
      cmpA_ff <= nxt_cmpA;
      cmpB_ff <= nxt_cmpB;
      cmpABuf_ff <= nxt_cmpABuf;
      cmpBBuf_ff <= nxt_cmpBBuf;
      cap_ff <= nxt_cap;
      temp_ff <= nxt_temp;
      ctrlA_ff <= nxt_ctrlA;
      ctrlB_ff <= nxt_ctrlB;
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
      rdData_ff <= nxt_rdData;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpuRdData = rdData_ff;
  assign counterValue = cnt_ff;
  assign topHit = atTop;
  assign bottomHit = atBottom;
  assign matchA = (cnt_ff == cmpA_ff);
  assign matchB = (cnt_ff == cmpB_ff);
  assign intReq = {flags_ff[timer16_pkg::FLAG_CAP], flags_ff[timer16_pkg::FLAG_CMPB],
                   flags_ff[timer16_pkg::FLAG_CMPA], flags_ff[timer16_pkg::FLAG_OVF]}
                & {mask_ff[timer16_pkg::FLAG_CAP], mask_ff[timer16_pkg::FLAG_CMPB],
                   mask_ff[timer16_pkg::FLAG_CMPA], mask_ff[timer16_pkg::FLAG_OVF]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_stopHolds;
    (ctrlB_ff[2:0] == timer16_pkg::CS_STOP) && !cntWr |=> $stable(cnt_ff);
  endproperty
  a_stopHolds: assert property (p_stopHolds) else $error("counter moved while stopped");

  property p_writeWins;
    cntWr |=> cnt_ff == {$past(temp_ff), $past(cpuWrData)};
  endproperty
  a_writeWins: assert property (p_writeWins) else $error("counter write lost");

  property p_lowReadLatch;
    cpuRdEn && !cpuWrEn && cpuSel == timer16_pkg::SEL_CNT_L
      ##1 cpuRdEn && !cpuWrEn && cpuSel == timer16_pkg::SEL_CNT_H
      |=> cpuRdData == $past(cnt_ff[15:8], 2);
  endproperty
  a_lowReadLatch: assert property (p_lowReadLatch) else $error("high byte not latched");

  property p_upCount;
    tick && mode == timer16_pkg::WM_NORMAL && !cntWr && cnt_ff != timer16_pkg::CNT_MAX
      |=> cnt_ff == 16'($past(cnt_ff) + timer16_pkg::CNT_ONE);
  endproperty
  a_upCount: assert property (p_upCount) else $error("bad increment");

  property p_downCount;
    tick && isDual(mode) && dir_ff == DIR_DOWN && !atBottom && !cntWr
      |=> cnt_ff == 16'($past(cnt_ff) - timer16_pkg::CNT_ONE);
  endproperty
  a_downCount: assert property (p_downCount) else $error("bad decrement");

  property p_normalWrap;
    tick && mode == timer16_pkg::WM_NORMAL && !cntWr && cnt_ff == timer16_pkg::CNT_MAX
      |=> cnt_ff == timer16_pkg::CNT_BOTTOM && flags_ff[timer16_pkg::FLAG_OVF];
  endproperty
  a_normalWrap: assert property (p_normalWrap) else $error("wrap or overflow wrong");

  property p_captureFlag;
    capEvent && !capIsTop(mode)
      |=> cap_ff == $past(cnt_ff) && flags_ff[timer16_pkg::FLAG_CAP];
  endproperty
  a_captureFlag: assert property (p_captureFlag) else $error("capture missed");

  property p_maskGate;
    !mask_ff[timer16_pkg::FLAG_OVF] |-> !intReq[0];
  endproperty
  a_maskGate: assert property (p_maskGate) else $error("masked request seen");

  property p_pwmTopHeld;
    isPwm(mode) && !bufLoad ##1 isPwm(mode) |-> $stable(cmpA_ff);
  endproperty
  a_pwmTopHeld: assert property (p_pwmTopHeld) else $error("buffer loaded early");

  c_dualTurn: cover property (tick && isDual(mode) && dir_ff == DIR_UP && atTop);
  c_capture: cover property (capEvent && !capIsTop(mode));
  c_overflow: cover property (flagSet[timer16_pkg::FLAG_OVF]);
endmodule

//--- verification/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clk,
  output logic [3:0] cpuSel,
  output logic cpuWrEn,
  output logic cpuRdEn,
  output logic [7:0] cpuWrData,
  input wire logic [7:0] cpuRdData
);
  initial begin
    cpuSel = 4'h0;
    cpuWrEn = 1'b0;
    cpuRdEn = 1'b0;
    cpuWrData = 8'h00;
  end
  // ----------------------------------------------------------------
  // Byte cycles
  // ----------------------------------------------------------------
  // Idle bus lines flip so a stale value is never mistaken for data
  task automatic wr(input logic [3:0] sel, input logic [7:0] data);
    @(posedge clk);
    #1;
    cpuSel = sel;
    cpuWrData = data;
    cpuWrEn = 1'b1;
    @(posedge clk);
    #1;
    cpuWrEn = 1'b0;
    cpuSel = ~cpuSel;
    cpuWrData = ~cpuWrData;
  endtask
  task automatic rd(input logic [3:0] sel, output logic [7:0] data);
    @(posedge clk);
    #1;
    cpuSel = sel;
    cpuRdEn = 1'b1;
    @(posedge clk);
    #1;
    cpuRdEn = 1'b0;
    cpuSel = ~cpuSel;
    data = cpuRdData;
  endtask
  // ----------------------------------------------------------------
  // Word cycles through the shared high-byte latch
  // ----------------------------------------------------------------
  task automatic wr16(input logic [3:0] selLow, input logic [15:0] val);
    wr(selLow + 4'h1, val[15:8]);
    wr(selLow, val[7:0]);
  endtask
  // Low then high on back-to-back cycles, so the latch is read at the next edge
  task automatic rd16(input logic [3:0] selLow, output logic [15:0] val);
    @(posedge clk);
    #1;
    cpuSel = selLow;
    cpuRdEn = 1'b1;
    @(posedge clk);
    #1;
    val[7:0] = cpuRdData;
    cpuSel = selLow + 4'h1;
    @(posedge clk);
    #1;
    val[15:8] = cpuRdData;
    cpuRdEn = 1'b0;
    cpuSel = ~cpuSel;
  endtask
endmodule

//--- verification/timer16_counter_core_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module timer16_counter_core_tb_top;
  logic clk;
  logic arst_n;
  logic [3:0] cpuSel;
  logic cpuWrEn;
  logic cpuRdEn;
  logic [7:0] cpuWrData;
  logic [7:0] cpuRdData;
  logic [4:0] prescTaps;
  logic extCountPin;
  logic capturePin;
  logic comparatorOut;
  logic acCaptureSel;
  logic [15:0] counterValue;
  logic topHit;
  logic bottomHit;
  logic matchA;
  logic matchB;
  logic [3:0] intReq;
  int fails;
  int samplesChecked;
  int seed;
  int mCnt;
  int mTop;
  bit mDual;
  bit mUp;
  int i;
  int code;
  logic [15:0] expVal;
  logic [15:0] rdVal;
  logic [7:0] rdByte;
  logic [3:0] selLow;
  timer16_counter_core u_timer16_counter_core (.clk(clk), .arst_n(arst_n), .cpuSel(cpuSel),
    .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn), .cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
    .prescTaps(prescTaps), .extCountPin(extCountPin), .capturePin(capturePin),
    .comparatorOut(comparatorOut), .acCaptureSel(acCaptureSel),
    .counterValue(counterValue), .topHit(topHit),
    .bottomHit(bottomHit), .matchA(matchA), .matchB(matchB), .intReq(intReq));
  cpu_bus_model u_cpu_bus_model (.clk(clk), .cpuSel(cpuSel), .cpuWrEn(cpuWrEn),
    .cpuRdEn(cpuRdEn), .cpuWrData(cpuWrData), .cpuRdData(cpuRdData));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // ----------------------------------------------------------------
  // Reference counter and stimulus helpers
  // ----------------------------------------------------------------
  task automatic modelStep();
    if (mDual) begin
      if (mUp && mCnt == mTop) mUp = 1'b0;
      else if (!mUp && mCnt == 0) mUp = 1'b1;
      mCnt = mUp ? mCnt + 1 : mCnt - 1;
    end else begin
      mCnt = (mCnt == mTop) ? 0 : (mCnt + 1) & 32'hffff;
    end
  endtask
  task automatic tapPulse(input logic [4:0] taps, input bit counts);
    @(posedge clk);
    #1;
    prescTaps = taps;
    @(posedge clk);
    #1;
    prescTaps = 5'h00;
    if (counts) modelStep();
  endtask
  task automatic extEdge(input logic v, input bit counts);
    @(posedge clk);
    #1;
    extCountPin = v;
    repeat (2) @(posedge clk);
    #1;
    if (counts) modelStep();
  endtask
  task automatic setCnt(input logic [15:0] v);
    u_cpu_bus_model.wr16(timer16_pkg::SEL_CNT_L, v);
    mCnt = int'(v);
  endtask
  task automatic wrap_up();
    $display("Comparisons: %0d, mismatches: %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    fails++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    prescTaps = 5'h00;
    extCountPin = 1'b0;
    capturePin = 1'b0;
    comparatorOut = 1'b0;
    acCaptureSel = 1'b0;
    fails = 0;
    samplesChecked = 0;
    seed = 32'h7c30;
    mCnt = 0;
    mTop = 32'hffff;
    mDual = 1'b0;
    mUp = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    `CHK(counterValue, 16'h0000)
    `CHK({topHit, bottomHit, intReq}, 6'h10)
    for (i = 0; i < 4; i++) begin
      expVal = 16'($random(seed));
      setCnt(expVal);
      u_cpu_bus_model.rd16(timer16_pkg::SEL_CNT_L, rdVal);
      `CHK(counterValue, expVal)
      `CHK(rdVal, expVal)
    end
    // High read must return the byte latched before the step
    expVal = {8'($random(seed)), 8'hff};
    setCnt(expVal);
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h01);
    u_cpu_bus_model.rd(timer16_pkg::SEL_CNT_L, rdVal[7:0]);
    tapPulse(5'h01, 1'b1);
    u_cpu_bus_model.rd(timer16_pkg::SEL_CNT_H, rdVal[15:8]);
    `CHK(rdVal, expVal)
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h00);
    tapPulse(5'h1f, 1'b0);
    extEdge(1'b1, 1'b0);
    extEdge(1'b0, 1'b0);
    `CHK(counterValue, 16'(mCnt))
    for (code = 1; code <= 5; code++) begin
      u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'(code));
      tapPulse(~(5'h01 << (code - 1)), 1'b0);
      tapPulse(5'h01 << (code - 1), 1'b1);
      `CHK(counterValue, 16'(mCnt))
    end
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h07);
    extEdge(1'b1, 1'b1);
    extEdge(1'b0, 1'b0);
    `CHK(counterValue, 16'(mCnt))
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h06);
    extEdge(1'b1, 1'b0);
    extEdge(1'b0, 1'b1);
    `CHK(counterValue, 16'(mCnt))
    // Low-byte write lands on the same edge as a tick
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h01);
    expVal = 16'($random(seed));
    fork
      u_cpu_bus_model.wr16(timer16_pkg::SEL_CNT_L, expVal);
      begin
        repeat (3) @(posedge clk);
        #1;
        prescTaps = 5'h01;
        @(posedge clk);
        #1;
        prescTaps = 5'h00;
      end
    join
    mCnt = int'(expVal);
    `CHK(counterValue, expVal)
    // Dual slope, eight-bit top: turns round at 00ff
    setCnt(16'h00fd);
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_A, 8'h01);
    mDual = 1'b1;
    mTop = 32'h00ff;
    for (i = 0; i < 4; i++) begin
      tapPulse(5'h01, 1'b1);
      `CHK(counterValue, 16'(mCnt))
      `CHK(topHit, 1'(mCnt == mTop))
    end
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_A, 8'h00);
    mDual = 1'b0;
    // Clear on compare A top
    u_cpu_bus_model.wr16(timer16_pkg::SEL_CMPA_L, 16'h0003);
    setCnt(16'h0000);
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h09);
    mTop = 3;
    for (i = 0; i < 5; i++) begin
      tapPulse(5'h01, 1'b1);
      `CHK({topHit, counterValue}, {1'(mCnt == 3), 16'(mCnt)})
    end
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h01);
    mTop = 32'hffff;
    // Compare A as top in a PWM mode: a new top only takes effect at the wrap
    u_cpu_bus_model.wr16(timer16_pkg::SEL_CMPA_L, 16'h0005);
    setCnt(16'h0000);
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_A, 8'h03);
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h19);
    u_cpu_bus_model.wr16(timer16_pkg::SEL_CMPA_L, 16'h0002);
    mTop = 5;
    for (i = 0; i < 9; i++) begin
      code = mCnt;
      tapPulse(5'h01, 1'b1);
      if (code == mTop) mTop = 2;
      `CHK({topHit, counterValue}, {1'(mCnt == mTop), 16'(mCnt)})
    end
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_A, 8'h00);
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h01);
    mTop = 32'hffff;
    // Overflow flag with masking and write-one clear
    u_cpu_bus_model.wr(timer16_pkg::SEL_FLAGS, 8'h27);
    u_cpu_bus_model.wr(timer16_pkg::SEL_MASK, 8'h01);
    setCnt(16'hffff);
    tapPulse(5'h01, 1'b1);
    `CHK({bottomHit, intReq}, 5'h11)
    u_cpu_bus_model.wr(timer16_pkg::SEL_MASK, 8'h00);
    `CHK(intReq, 4'h0)
    u_cpu_bus_model.wr(timer16_pkg::SEL_MASK, 8'h01);
    `CHK(intReq, 4'h1)
    u_cpu_bus_model.wr(timer16_pkg::SEL_FLAGS, 8'h01);
    `CHK(intReq, 4'h0)
    for (i = 0; i < 2; i++) begin
      selLow = i ? timer16_pkg::SEL_CMPB_L : timer16_pkg::SEL_CMPA_L;
      expVal = 16'($random(seed));
      u_cpu_bus_model.wr16(selLow, expVal);
      setCnt(expVal);
      u_cpu_bus_model.wr(timer16_pkg::SEL_FLAGS, 8'h27);
      u_cpu_bus_model.wr(timer16_pkg::SEL_MASK, 8'h06);
      `CHK({matchB, matchA}, 2'(1 << i))
      tapPulse(5'h01, 1'b1);
      `CHK(intReq, 4'(2 << i))
    end
    expVal[7:0] = 8'($random(seed)) & 8'hc7;
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, expVal[7:0]);
    u_cpu_bus_model.rd(timer16_pkg::SEL_CTRL_B, rdByte);
    `CHK(rdByte, expVal[7:0] & timer16_pkg::CTRLB_RW_MASK)
    // Capture with the counter stopped, filter off then on
    u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'h40);
    u_cpu_bus_model.wr(timer16_pkg::SEL_MASK, 8'h20);
    u_cpu_bus_model.wr(timer16_pkg::SEL_FLAGS, 8'h27);
    for (i = 0; i < 2; i++) begin
      setCnt(16'($random(seed)));
      @(posedge clk);
      #1;
      capturePin = 1'b1;
      repeat (i ? 5 : 3) @(posedge clk);
      #1;
      `CHK(intReq, i ? 4'h0 : 4'h8)
      repeat (i ? 3 : 0) @(posedge clk);
      `CHK(intReq, 4'h8)
      u_cpu_bus_model.rd16(timer16_pkg::SEL_CAP_L, rdVal);
      `CHK(rdVal, 16'(mCnt))
      u_cpu_bus_model.wr(timer16_pkg::SEL_CTRL_B, 8'hc0);
      capturePin = 1'b0;
      repeat (10) @(posedge clk);
      u_cpu_bus_model.wr(timer16_pkg::SEL_FLAGS, 8'h20);
    end
    // Comparator output as capture source, filter still on
    acCaptureSel = 1'b1;
    setCnt(16'($random(seed)));
    @(posedge clk);
    #1;
    comparatorOut = 1'b1;
    repeat (7) @(posedge clk);
    #1;
    `CHK(intReq, 4'h8)
    u_cpu_bus_model.rd16(timer16_pkg::SEL_CAP_L, rdVal);
    `CHK(rdVal, 16'(mCnt))
    wrap_up();
  end
endmodule
